//--- hw/wec_pkg.sv
// constants and types of the wake-up event counter
package wec_pkg;

   //==========================================================
   // bus and register map
   localparam int          DATA_W     = 16;
   localparam logic [31:0] OFS_CTRL   = 32'h5000_0100;
   localparam logic [31:0] OFS_CMP    = 32'h5000_0102;
   localparam logic [31:0] OFS_IRQCLR = 32'h5000_0104;
   localparam logic [31:0] OFS_COUNT  = 32'h5000_0106;
   localparam logic [31:0] OFS_CNTCLR = 32'h5000_0108;
   localparam logic [31:0] OFS_MASK [4] = '{32'h5000_010a, 32'h5000_010c,
                                           32'h5000_010e, 32'h5000_0110};
   localparam logic [31:0] OFS_POL  [4] = '{32'h5000_0112, 32'h5000_0114,
                                           32'h5000_0116, 32'h5000_0118};

   //==========================================================
   // fields and reset values
   localparam int         IRQ_EN_BIT = 7;
   localparam int         SOFT_BIT   = 6;
   localparam int         DEB_W      = 6;
   localparam int         CMP_W      = 8;
   localparam int         CNT_W      = 8;
   localparam logic [5:0] DEB_OFF    = 6'h00;
   localparam logic [5:0] DEB_LAST   = 6'h01;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] CMP_RST    = 8'h00;
   localparam logic [7:0] CNT_RST    = 8'h00;
   localparam logic [15:0] MASK_RST  = 16'h0000;
   localparam logic [15:0] POL_RST   = 16'h0000;

   //==========================================================
   // ports: pin widths and positions in the flat pin vector
   localparam int PIN_W      = 32;
   localparam int PORT_W  [4] = '{8, 6, 10, 8};
   localparam int PORT_LO [4] = '{0, 8, 14, 24};

   //==========================================================
   // timing
   localparam int CLK_NS     = 100;
   localparam int DEB_STEP_NS = 1000000;
   localparam int MS_CYCLES  = DEB_STEP_NS / CLK_NS;
   localparam int PRESC_W    = 14;

   //==========================================================
   // types
   typedef struct packed {
      logic [7:0] p3;
      logic [9:0] p2;
      logic [5:0] p1;
      logic [7:0] p0;
   } wec_pins_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } wec_bus_t;

   typedef enum logic [1:0] {DB_IDLE, DB_WAIT, DB_HELD} wec_deb_state_t;

endpackage

//--- hw/wec_top.sv
// wake-up event counter: pin select, debounce, event counter, interrupt
//==========================================================
// Overview of operation
// R1 - debounce N ms, zero disables debouncing
// R2 - soft key bit counts one debounced hit
// R3 - software clears soft key before next hit
// R4 - enabled interrupt when count reaches compare
// R5 - eight-bit writable compare value
// R6 - any write clears interrupt, reads zero
// R7 - count readable, cleared with interrupt clear
// R8 - any write clears event counter
// R9 - port 0 eight-bit pin select mask
// R10 - port 1 six-bit pin select mask
// R11 - port 2 ten-bit pin select mask
// R12 - port 3 eight-bit pin select mask
// R13 - polarity bit picks rising or falling input
// R14 - interrupt held until software clears it
//
// The implementer's own choice: the plain strobed port.
module wec_top
#(
   parameter int TICK_CYCLES = wec_pkg::MS_CYCLES
)
(
   // clock and reset
   input  logic               ref_clk,
   input  logic               rst_n,
   // register port
   input  wec_pkg::wec_bus_t  bus,
   output logic [15:0]        rd_data,
   // wake pins
   input  wec_pkg::wec_pins_t pins,
   // interrupt
   output logic               wake_irq
);

   //==========================================================
   // declarations
   localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

   logic                   wake_irq_enable;
   logic                   soft_key_emulate;
   logic [5:0]             debounce_ms;
   logic [7:0]             cmp;
   logic [7:0]             count;
   logic [31:0]            pin_vec;
   logic [31:0]            mask;
   logic [31:0]            pol;
   logic [15:0]            port_rd [4];
   wec_pkg::wec_deb_state_t state;
   wec_pkg::wec_deb_state_t next_state;
   logic [5:0]             remaining;
   logic [5:0]             next_remaining;
   logic [13:0]            presc;
   logic [13:0]            next_presc;
   logic [7:0]             next_count;
   logic                   next_irq;
   logic [15:0]            next_rd;

   //==========================================================
   // address decode
   wire wr_ctrl   = bus.wr && bus.addr == wec_pkg::OFS_CTRL;
   wire wr_cmp    = bus.wr && bus.addr == wec_pkg::OFS_CMP;
   wire wr_irqclr = bus.wr && bus.addr == wec_pkg::OFS_IRQCLR;
   wire wr_cntclr = bus.wr && bus.addr == wec_pkg::OFS_CNTCLR;
   wire rd_irqclr = bus.rd && bus.addr == wec_pkg::OFS_IRQCLR;
   wire rd_count  = bus.rd && bus.addr == wec_pkg::OFS_COUNT;
   wire clr_cnt   = wr_irqclr || wr_cntclr;

   //==========================================================
   // control and compare registers
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         {wake_irq_enable, soft_key_emulate, debounce_ms} <= wec_pkg::CTRL_RST;
         cmp <= wec_pkg::CMP_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            wake_irq_enable  <= bus.wdata[wec_pkg::IRQ_EN_BIT];
            soft_key_emulate <= bus.wdata[wec_pkg::SOFT_BIT];
            debounce_ms      <= bus.wdata[wec_pkg::DEB_W-1:0];
         end
         if (wr_cmp)
         begin
            cmp <= bus.wdata[wec_pkg::CMP_W-1:0]; // [R5]
         end
      end
   end

   //==========================================================
   // per-port select mask and polarity
   assign pin_vec = pins;

   for (genvar g = 0; g < 4; g++)
   begin : g_port
      localparam int W  = wec_pkg::PORT_W[g];
      localparam int LO = wec_pkg::PORT_LO[g];
      logic [W-1:0] m_q;
      logic [W-1:0] p_q;
      wire wr_m = bus.wr && bus.addr == wec_pkg::OFS_MASK[g];
      wire wr_p = bus.wr && bus.addr == wec_pkg::OFS_POL[g];
      wire rd_m = bus.addr == wec_pkg::OFS_MASK[g];
      wire rd_p = bus.addr == wec_pkg::OFS_POL[g];

      always_ff @(posedge ref_clk)
      begin
         if (!rst_n)
         begin
            m_q <= W'(wec_pkg::MASK_RST);
            p_q <= W'(wec_pkg::POL_RST);
         end
         else
         begin
            if (wr_m)
            begin
               m_q <= bus.wdata[W-1:0]; // [R9] [R10] [R11] [R12]
            end
            if (wr_p)
            begin
               p_q <= bus.wdata[W-1:0]; // [R13]
            end
         end
      end

      assign mask[LO +: W] = m_q;
      assign pol[LO +: W]  = p_q;
      assign port_rd[g]    = rd_m ? 16'(m_q) : rd_p ? 16'(p_q) : 16'h0000;
   end

   //==========================================================
   // key detection and debounce
   // unselected pins are dropped, polarity folds falling into rising
   wire [31:0] active    = (pin_vec ^ pol) & mask; // [R9] [R10] [R11] [R12] [R13]
   wire        key_level = |active || soft_key_emulate; // [R2]
   wire        tick      = state == wec_pkg::DB_WAIT && presc == TICK_LAST;
   wire        deb_off   = debounce_ms == wec_pkg::DEB_OFF;
   wire        last_ms   = remaining == wec_pkg::DEB_LAST;
   // a hit needs the level to drop first, so a held soft key counts once
   wire        hit       = (state == wec_pkg::DB_IDLE && key_level && deb_off) ||
                           (tick && key_level && last_ms); // [R1] [R3]

   always_comb
   begin
      next_state     = state;
      next_remaining = remaining;
      next_presc     = 14'h0000;
      unique case (state)
         wec_pkg::DB_IDLE:
         begin
            next_remaining = debounce_ms;
            if (key_level)
            begin
               next_state = deb_off ? wec_pkg::DB_HELD : wec_pkg::DB_WAIT; // [R1]
            end
         end
         wec_pkg::DB_WAIT:
         begin
            next_presc = tick ? 14'h0000 : presc + 14'h0001;
            if (!key_level)
            begin
               next_state = wec_pkg::DB_IDLE;
            end
            else if (tick)
            begin
               next_remaining = remaining - 6'h01;
               if (last_ms)
               begin
                  next_state = wec_pkg::DB_HELD;
               end
            end
         end
         wec_pkg::DB_HELD:
         begin
            if (!key_level)
            begin
               next_state = wec_pkg::DB_IDLE; // [R3]
            end
         end
      endcase
   end

   //==========================================================
   // event counter and interrupt
   // an increment in the cycle of a clear survives as a count of one
   always_comb
   begin
      next_count = count;
      if (clr_cnt)
      begin
         next_count = wec_pkg::CNT_RST; // [R7] [R8]
      end
      if (hit)
      begin
         next_count = clr_cnt ? 8'h01 : count + 8'h01; // [R2]
      end
   end

   wire irq_set = hit && wake_irq_enable && next_count == cmp; // [R4]

   // set wins over clear
   assign next_irq = irq_set || (wake_irq && !wr_irqclr); // [R6] [R14]

   //==========================================================
   // read mux, one cycle latency
   wire [15:0] ctrl_rd = {8'h00, wake_irq_enable, soft_key_emulate, debounce_ms};
   wire [15:0] reg_rd  = (bus.addr == wec_pkg::OFS_CTRL)  ? ctrl_rd :
                         (bus.addr == wec_pkg::OFS_CMP)   ? {8'h00, cmp} :
                         (bus.addr == wec_pkg::OFS_COUNT) ? {8'h00, count} : // [R7]
                         16'h0000; // [R6]

   assign next_rd = bus.rd ? (reg_rd | port_rd[0] | port_rd[1] |
                              port_rd[2] | port_rd[3]) : 16'h0000;

   //==========================================================
   // state registers
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state     <= wec_pkg::DB_HELD;
         remaining <= wec_pkg::DEB_OFF;
         presc     <= 14'h0000;
         count     <= wec_pkg::CNT_RST;
         wake_irq  <= 1'b0;
         rd_data   <= 16'h0000;
      end
      else
      begin
         state     <= next_state;
         remaining <= next_remaining;
         presc     <= next_presc;
         count     <= next_count;
         wake_irq  <= next_irq;
         rd_data   <= next_rd;
      end
   end

   //==========================================================
   // assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_deb_start;
      state == wec_pkg::DB_IDLE && key_level && !deb_off;
   endsequence

   sequence s_deb_wait;
      state == wec_pkg::DB_WAIT && remaining == $past(debounce_ms);
   endsequence

   property p_deb_zero;
      state == wec_pkg::DB_IDLE && soft_key_emulate && deb_off && !clr_cnt
         |=> count == $past(count) + 8'h01;
   endproperty
   a_deb_zero: assert property (p_deb_zero) // [R1]
      else $error("no count without debounce");

   property p_deb_wait;
      s_deb_start |=> s_deb_wait;
   endproperty
   a_deb_wait: assert property (p_deb_wait) // [R1]
      else $error("debounce wait not entered");

   property p_deb_done;
      hit && state == wec_pkg::DB_WAIT |-> $past(state) == wec_pkg::DB_WAIT && $past(key_level);
   endproperty
   a_deb_done: assert property (p_deb_done) // [R1]
      else $error("count before debounce time");

   property p_soft;
      wr_ctrl && bus.wdata[wec_pkg::SOFT_BIT] && bus.wdata[5:0] == wec_pkg::DEB_OFF
         && !soft_key_emulate && state == wec_pkg::DB_IDLE && !key_level |=> hit;
   endproperty
   a_soft: assert property (p_soft) // [R2]
      else $error("soft key not counted");

   property p_irq_set;
      irq_set |=> wake_irq;
   endproperty
   a_irq_set: assert property (p_irq_set) // [R4]
      else $error("irq missed on compare");

   property p_irq_gate;
      $rose(wake_irq) |-> $past(wake_irq_enable) && $past(hit);
   endproperty
   a_irq_gate: assert property (p_irq_gate) // [R4]
      else $error("irq while disabled");

   property p_cmp_wr;
      wr_cmp |=> cmp == $past(bus.wdata[7:0]);
   endproperty
   a_cmp_wr: assert property (p_cmp_wr) // [R5]
      else $error("compare not written");

   property p_irq_clr;
      wr_irqclr && !hit |=> !wake_irq && count == 8'h00;
   endproperty
   a_irq_clr: assert property (p_irq_clr) // [R6] [R7]
      else $error("irq clear failed");

   property p_clr_read;
      rd_irqclr |=> rd_data == 16'h0000;
   endproperty
   a_clr_read: assert property (p_clr_read) // [R6]
      else $error("clear register read not zero");

   property p_cnt_read;
      rd_count |=> rd_data == {8'h00, $past(count)};
   endproperty
   a_cnt_read: assert property (p_cnt_read) // [R7]
      else $error("count read wrong");

   property p_cnt_clr;
      wr_cntclr && !hit |=> count == 8'h00;
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) // [R8]
      else $error("count clear failed");

   property p_mask;
      state == wec_pkg::DB_IDLE && active == 32'h0000_0000 && !soft_key_emulate
         |=> count == $past(count) || count == 8'h00;
   endproperty
   a_mask: assert property (p_mask) // [R9] [R10] [R11] [R12]
      else $error("masked pin counted");

   property p_pol;
      state == wec_pkg::DB_IDLE && deb_off && !clr_cnt && active != 32'h0000_0000
         |=> count == $past(count) + 8'h01;
   endproperty
   a_pol: assert property (p_pol) // [R13]
      else $error("active pin edge not counted");

   property p_irq_hold;
      wake_irq && !wr_irqclr |=> wake_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) // [R14]
      else $error("irq dropped without clear");

endmodule

//--- test/wec_key_model.sv
// behavioural model of keys and wake signals on the port pins
module wec_key_model
(
   // clock
   input  logic               ref_clk,
   // key levels set by the bench
   input  logic [31:0]        idle_lvl,
   input  logic [31:0]        press,
   // pins toward the counter
   output wec_pkg::wec_pins_t pins
);
   timeunit 1ns;
   timeprecision 100ps;

   //==========================================================
   // a pressed key flips its pin away from its resting level
   always_ff @(posedge ref_clk)
   begin
      pins <= idle_lvl ^ press;
   end
endmodule

//--- test/tb_top.sv
// self-checking bench of the wake-up event counter
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   //==========================================================
   // signals and tables
   localparam int          TICK = 4;
   localparam logic [31:0] UNMAPPED = 32'h5000_0120;
   localparam logic [31:0] RST_TAB [10] = '{wec_pkg::OFS_CTRL, wec_pkg::OFS_CMP,
      wec_pkg::OFS_IRQCLR, wec_pkg::OFS_COUNT, wec_pkg::OFS_CNTCLR, wec_pkg::OFS_MASK[0],
      wec_pkg::OFS_MASK[1], wec_pkg::OFS_MASK[2], wec_pkg::OFS_MASK[3], UNMAPPED};
   localparam logic [15:0] MASK_ALL [4] = '{16'h00ff, 16'h003f, 16'h03ff, 16'h00ff};
   localparam logic [15:0] MASK_TOP [4] = '{16'h0080, 16'h0020, 16'h0200, 16'h0080};
   localparam int          PIN_TOP  [4] = '{7, 13, 23, 31};
   logic                   ref_clk;
   logic                   rst_n;
   wec_pkg::wec_bus_t      bus;
   logic [15:0]            rd_data;
   wec_pkg::wec_pins_t     pins;
   logic                   wake_irq;
   logic [31:0]            idle_lvl;
   logic [31:0]            press;
   int                     n_fail;
   int                     samples_checked;

   wec_top #(.TICK_CYCLES(TICK)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
      .rd_data(rd_data), .pins(pins), .wake_irq(wake_irq));
   wec_key_model keys (.ref_clk(ref_clk), .idle_lvl(idle_lvl), .press(press), .pins(pins));

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   //==========================================================
   // tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1;
      chk(rd_data, exp);
   endtask

   task automatic soft_hit(input logic [15:0] base);
      wr(wec_pkg::OFS_CTRL, base | 16'h0040);
      wr(wec_pkg::OFS_CTRL, base);
      cyc(3);
   endtask

   task automatic key(input int b, input int hold);
      @(posedge ref_clk);
      press <= 32'h1 << b;
      repeat (hold) @(posedge ref_clk);
      press <= '0;
      cyc(4);
   endtask

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   //==========================================================
   // watchdog
   initial
   begin
      #2000000;
      n_fail++;
      close_out();
   end

   //==========================================================
   // tests
   initial
   begin
      n_fail = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      bus = '0;
      idle_lvl = '0;
      press = '0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      foreach (RST_TAB[i]) rd(RST_TAB[i], 16'h0000);
      for (int k = 0; k < 4; k++) rd(wec_pkg::OFS_POL[k], 16'h0000);
      $display("test reset values done");

      wr(wec_pkg::OFS_CTRL, 16'hffbf);
      rd(wec_pkg::OFS_CTRL, 16'h00bf);
      wr(wec_pkg::OFS_CMP, 16'hffff);
      rd(wec_pkg::OFS_CMP, 16'h00ff);
      for (int k = 0; k < 4; k++)
      begin
         wr(wec_pkg::OFS_MASK[k], 16'hffff);
         rd(wec_pkg::OFS_MASK[k], MASK_ALL[k]);
         wr(wec_pkg::OFS_MASK[k], 16'h0000);
         wr(wec_pkg::OFS_POL[k], 16'hffff);
         rd(wec_pkg::OFS_POL[k], MASK_ALL[k]);
         wr(wec_pkg::OFS_POL[k], 16'h0000);
      end
      wr(wec_pkg::OFS_COUNT, 16'h00aa);
      rd(wec_pkg::OFS_COUNT, 16'h0000);
      cyc(1);
      chk(rd_data, 16'h0000);
      wr(wec_pkg::OFS_CTRL, 16'h0000);
      wr(wec_pkg::OFS_CMP, 16'h0000);
      $display("test register widths done");

      wr(wec_pkg::OFS_CTRL, 16'h0040);
      wr(wec_pkg::OFS_CTRL, 16'h0040);
      cyc(3);
      rd(wec_pkg::OFS_COUNT, 16'h0001);
      wr(wec_pkg::OFS_CTRL, 16'h0000);
      soft_hit(16'h0000);
      rd(wec_pkg::OFS_COUNT, 16'h0002);
      wr(wec_pkg::OFS_CNTCLR, 16'h5a3c);
      rd(wec_pkg::OFS_COUNT, 16'h0000);
      $display("test soft key done");

      wr(wec_pkg::OFS_CMP, 16'h0002);
      wr(wec_pkg::OFS_CTRL, 16'h0080);
      soft_hit(16'h0080);
      chk({15'h0, wake_irq}, 16'h0000);
      soft_hit(16'h0080);
      chk({15'h0, wake_irq}, 16'h0001);
      rd(wec_pkg::OFS_COUNT, 16'h0002);
      wr(wec_pkg::OFS_CTRL, 16'h0000);
      cyc(20);
      chk({15'h0, wake_irq}, 16'h0001);
      wr(wec_pkg::OFS_IRQCLR, 16'h0000);
      cyc(1);
      chk({15'h0, wake_irq}, 16'h0000);
      rd(wec_pkg::OFS_COUNT, 16'h0000);
      wr(wec_pkg::OFS_CMP, 16'h0001);
      soft_hit(16'h0000);
      chk({15'h0, wake_irq}, 16'h0000);
      rd(wec_pkg::OFS_COUNT, 16'h0001);
      wr(wec_pkg::OFS_CNTCLR, 16'hffff);
      $display("test interrupt done");

      for (int k = 0; k < 4; k++)
      begin
         wr(wec_pkg::OFS_MASK[k], MASK_TOP[k]);
         key(PIN_TOP[k], 3);
         key(PIN_TOP[k] - 1, 3);
         rd(wec_pkg::OFS_COUNT, 16'(k + 1));
         wr(wec_pkg::OFS_MASK[k], 16'h0000);
      end
      @(posedge ref_clk);
      idle_lvl <= 32'h1;
      wr(wec_pkg::OFS_POL[0], 16'h0001);
      wr(wec_pkg::OFS_MASK[0], 16'h0001);
      cyc(4);
      rd(wec_pkg::OFS_COUNT, 16'h0004);
      key(0, 3);
      rd(wec_pkg::OFS_COUNT, 16'h0005);
      wr(wec_pkg::OFS_MASK[0], 16'h0000);
      wr(wec_pkg::OFS_POL[0], 16'h0000);
      @(posedge ref_clk);
      idle_lvl <= '0;
      $display("test pins and polarity done");

      wr(wec_pkg::OFS_CNTCLR, 16'h0000);
      wr(wec_pkg::OFS_MASK[0], 16'h0001);
      wr(wec_pkg::OFS_CTRL, 16'h0002);
      key(0, 2 * TICK - 2);
      rd(wec_pkg::OFS_COUNT, 16'h0000);
      key(0, 2 * TICK + 6);
      rd(wec_pkg::OFS_COUNT, 16'h0001);
      wr(wec_pkg::OFS_CTRL, 16'h0042);
      cyc(2 * TICK + 4);
      wr(wec_pkg::OFS_CTRL, 16'h0002);
      cyc(3);
      rd(wec_pkg::OFS_COUNT, 16'h0002);
      $display("test debounce done");
      close_out();
   end
endmodule
